// >>> hdl/acsu_pkg.sv
// Constants and types for the accumulator and stack unit.
// Overview of operation
// [RULE1] A 32-bit accumulator is cleared to zero at every end of scan.
// [RULE2] First load in a scan writes directly; later loads push first.
// [RULE3] After an output the next load overwrites without any push.
// [RULE4] A push moves every stack entry down and puts the value on top.
// [RULE5] Eight 32-bit levels; a push when full loses the bottom value.
// [RULE6] Pop drops the accumulator, takes the top entry, shifts stack up.
// [RULE7] Word load puts 16 bits in the low half and zeroes the high half.
// [RULE8] Double load fills all 32 bits from two words or a constant.
// [RULE9] Double output writes all 32 bits into two consecutive words.
// [RULE10] The zero flag is set whenever a loaded value equals zero.
// [RULE11] Pointer loads read a word address then load the word it names.
// [RULE12] A data manipulation result replaces the accumulator value.
// [RULE13] Single output copies the low 16 accumulator bits to memory.
// [RULE14] Lower word address maps to bits 15:0, next word to bits 31:16.
package acsu_pkg;

   localparam int ACC_W       = 32;
   localparam int WORD_W      = 16;
   localparam int STACK_DEPTH = 8;
   localparam int LO_LSB      = 0;
   localparam int HI_LSB      = 16;
   localparam logic [31:0] ACC_RESET  = 32'h0000_0000;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] ADDR_STEP  = 16'h0001;

   typedef enum logic [2:0] {
      nop_op              = 3'h0,
      load_word_op        = 3'h1,
      load_double_word_op = 3'h2,
      out_word_op         = 3'h3,
      out_double_word_op  = 3'h4,
      pop_op              = 3'h5,
      manip_op            = 3'h6
   } acsu_op_type;

   typedef enum logic [2:0] {
      st_idle     = 3'h0,
      st_ptr_wait = 3'h1,
      st_ptr_data = 3'h2,
      st_lo_wait  = 3'h3,
      st_lo_data  = 3'h4,
      st_hi_wait  = 3'h5,
      st_hi_data  = 3'h6,
      st_wr_hi    = 3'h7
   } acsu_state_type;

endpackage

// >>> hdl/acsu_stack_if.sv
// Link between the accumulator control and the push-down stack.
`timescale 1ns/100ps
interface acsu_stack_if;
   logic                     push;
   logic                     pop;
   logic [acsu_pkg::ACC_W-1:0] push_data;
   logic [acsu_pkg::ACC_W-1:0] top;
   logic [3:0]               depth;

   modport ctrl  (output push, output pop, output push_data,
                  input top, input depth);
   modport store (input push, input pop, input push_data,
                  output top, output depth);
endinterface

// >>> hdl/acsu_stack.sv
// Eight-level push-down stack behind the accumulator.
`timescale 1ns/100ps
module acsu_stack
#(
   parameter int DEPTH = acsu_pkg::STACK_DEPTH,
   parameter int W     = acsu_pkg::ACC_W
)
(
   // Clock and reset.
   input  wire logic  ref_clk,
   input  wire logic  resetn,
   // Controller side.
   acsu_stack_if.store st
);

   logic [W-1:0] lvl_q [DEPTH];
   logic [W-1:0] lvl_d [DEPTH];
   logic [3:0]   cnt_q;
   logic [3:0]   cnt_d;

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_lvl
         always_comb
         begin
            lvl_d[g] = lvl_q[g];
            if (st.push)
            begin
               // The old bottom entry is simply overwritten and lost.
               lvl_d[g] = (g == 0) ? st.push_data : lvl_q[(g == 0) ? 0 : g-1]; // RULE4 RULE5
            end
            else if (st.pop)
            begin
               lvl_d[g] = (g == DEPTH-1) ? acsu_pkg::ACC_RESET
                                         : lvl_q[(g == DEPTH-1) ? g : g+1]; // RULE6
            end
         end

         always_ff @(posedge ref_clk)
         begin
            if (!resetn)
               lvl_q[g] <= acsu_pkg::ACC_RESET;
            else
               lvl_q[g] <= lvl_d[g];
         end
      end
   endgenerate

   always_comb
   begin
      cnt_d = cnt_q;
      if (st.push && cnt_q != 4'(DEPTH))
         cnt_d = cnt_q + 4'h1; // RULE5
      else if (st.pop && cnt_q != 4'h0)
         cnt_d = cnt_q - 4'h1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
         cnt_q <= 4'h0;
      else
         cnt_q <= cnt_d;
   end

   assign st.top   = lvl_q[0];
   assign st.depth = cnt_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_push_shift_down: assert property (st.push |=> lvl_q[0] == $past(st.push_data) && lvl_q[1] == $past(lvl_q[0])) // RULE4
      else $error("Push did not shift the stack down.");
   a_full_stays_full: assert property (st.push && cnt_q == 4'(DEPTH) |=> cnt_q == 4'(DEPTH) && lvl_q[DEPTH-1] == $past(lvl_q[DEPTH-2])) // RULE5
      else $error("Push on a full stack mishandled the bottom level.");
   a_pop_shift_up: assert property (st.pop && !st.push |=> lvl_q[0] == $past(lvl_q[1]) && lvl_q[DEPTH-1] == acsu_pkg::ACC_RESET) // RULE6
      else $error("Pop did not shift the stack up.");

endmodule // acsu_stack

// >>> hdl/acsu_top.sv
// Accumulator with push-down stack, driven by the instruction sequencer.
`timescale 1ns/100ps
module acsu_top
(
   // Clock and reset.
   input  wire logic                  ref_clk,
   input  wire logic                  resetn,
   // Operation request from the sequencer.
   input  wire logic                  op_valid,
   output wire logic                  op_ready,
   input  wire acsu_pkg::acsu_op_type op_code,
   input  wire logic                  op_use_const,
   input  wire logic                  op_indirect,
   input  wire logic [15:0]           op_addr,
   input  wire logic [31:0]           op_operand,
   input  wire logic                  end_of_scan,
   // Word-wide data memory port.
   output wire logic                  mem_rd_en,
   output wire logic                  mem_wr_en,
   output wire logic [15:0]           mem_addr,
   output wire logic [15:0]           mem_wr_data,
   input  wire logic [15:0]           mem_rd_data,
   // Status.
   output wire logic [31:0]           acc_value,
   output wire logic [31:0]           stack_top,
   output wire logic [3:0]            stack_depth,
   output wire logic                  zero_load_flag
);

   localparam int WW = acsu_pkg::WORD_W;

   function automatic logic is_load(input acsu_pkg::acsu_op_type op);
      is_load = (op == acsu_pkg::load_word_op) ||
                (op == acsu_pkg::load_double_word_op);
   endfunction

   function automatic logic is_out(input acsu_pkg::acsu_op_type op);
      is_out = (op == acsu_pkg::out_word_op) ||
               (op == acsu_pkg::out_double_word_op);
   endfunction

   acsu_stack_if stk ();

   acsu_pkg::acsu_state_type state_q;
   acsu_pkg::acsu_state_type state_d;
   logic [31:0]              acc_q;
   logic [31:0]              acc_d;
   logic                     loaded_q;
   logic                     loaded_d;
   logic                     zero_q;
   logic                     zero_d;
   logic                     dbl_q;
   logic                     dbl_d;
   logic [15:0]              lo_q;
   logic [15:0]              lo_d;
   logic                     rd_q;
   logic                     rd_d;
   logic                     wr_q;
   logic                     wr_d;
   logic [15:0]              addr_q;
   logic [15:0]              addr_d;
   logic [15:0]              wdata_q;
   logic [15:0]              wdata_d;
   logic                     accept;
   logic                     load_commit;
   logic [31:0]              load_value;

   assign op_ready = (state_q == acsu_pkg::st_idle);
   assign accept   = op_valid && op_ready && !end_of_scan;

   always_comb
   begin
      load_commit = 1'b0;
      load_value  = acsu_pkg::ACC_RESET;
      if (accept && is_load(op_code) && op_use_const)
      begin
         load_commit = 1'b1;
         if (op_code == acsu_pkg::load_double_word_op)
            load_value = op_operand; // RULE8
         else
            load_value = {16'h0000, op_operand[WW-1:0]}; // RULE7
      end
      else if (state_q == acsu_pkg::st_lo_data && !dbl_q)
      begin
         load_commit = 1'b1;
         load_value  = {16'h0000, mem_rd_data}; // RULE7 RULE11
      end
      else if (state_q == acsu_pkg::st_hi_data)
      begin
         load_commit = 1'b1;
         load_value  = {mem_rd_data, lo_q}; // RULE8 RULE14
      end
   end

   // A load only pushes when an earlier load in this scan was not
   // followed by an output; the old value is pushed as the new one lands.
   assign stk.push      = load_commit && loaded_q && !end_of_scan; // RULE2 RULE3
   assign stk.pop       = accept && (op_code == acsu_pkg::pop_op); // RULE6
   assign stk.push_data = acc_q;

   always_comb
   begin
      state_d  = state_q;
      acc_d    = acc_q;
      loaded_d = loaded_q;
      zero_d   = zero_q;
      dbl_d    = dbl_q;
      lo_d     = lo_q;
      rd_d     = 1'b0;
      wr_d     = 1'b0;
      addr_d   = addr_q;
      wdata_d  = wdata_q;
      if (end_of_scan)
      begin
         // Scan end wins over any operation, and aborts a pending read.
         state_d  = acsu_pkg::st_idle;
         acc_d    = acsu_pkg::ACC_RESET; // RULE1
         loaded_d = 1'b0; // RULE2
      end
      else
      begin
         if (load_commit)
         begin
            acc_d    = load_value; // RULE2 RULE3
            loaded_d = 1'b1;
            zero_d   = (load_value == acsu_pkg::ACC_RESET); // RULE10
         end
         case (state_q)
            acsu_pkg::st_idle:
            begin
               if (accept)
               begin
                  dbl_d  = (op_code == acsu_pkg::load_double_word_op) ||
                           (op_code == acsu_pkg::out_double_word_op);
                  addr_d = op_addr;
                  if (is_load(op_code) && !op_use_const)
                  begin
                     rd_d    = 1'b1;
                     state_d = op_indirect ? acsu_pkg::st_ptr_wait
                                           : acsu_pkg::st_lo_wait; // RULE11
                  end
                  else if (is_out(op_code))
                  begin
                     loaded_d = 1'b0; // RULE3
                     wr_d     = 1'b1;
                     wdata_d  = acc_q[acsu_pkg::LO_LSB +: WW]; // RULE13 RULE14
                     if (op_code == acsu_pkg::out_double_word_op)
                        state_d = acsu_pkg::st_wr_hi; // RULE9
                  end
                  else if (op_code == acsu_pkg::pop_op)
                     acc_d = stk.top; // RULE6
                  else if (op_code == acsu_pkg::manip_op)
                     acc_d = op_operand; // RULE12
               end
            end
            acsu_pkg::st_ptr_wait:
               state_d = acsu_pkg::st_ptr_data;
            acsu_pkg::st_ptr_data:
            begin
               // The pointer word is taken as a plain binary word address.
               rd_d    = 1'b1;
               addr_d  = mem_rd_data; // RULE11
               state_d = acsu_pkg::st_lo_wait;
            end
            acsu_pkg::st_lo_wait:
               state_d = acsu_pkg::st_lo_data;
            acsu_pkg::st_lo_data:
            begin
               if (dbl_q)
               begin
                  lo_d    = mem_rd_data; // RULE14
                  rd_d    = 1'b1;
                  addr_d  = addr_q + acsu_pkg::ADDR_STEP;
                  state_d = acsu_pkg::st_hi_wait;
               end
               else
                  state_d = acsu_pkg::st_idle;
            end
            acsu_pkg::st_hi_wait:
               state_d = acsu_pkg::st_hi_data;
            acsu_pkg::st_hi_data:
               state_d = acsu_pkg::st_idle;
            acsu_pkg::st_wr_hi:
            begin
               wr_d    = 1'b1;
               addr_d  = addr_q + acsu_pkg::ADDR_STEP; // RULE9
               wdata_d = acc_q[acsu_pkg::HI_LSB +: WW]; // RULE14
               state_d = acsu_pkg::st_idle;
            end
            default:
               state_d = acsu_pkg::st_idle;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         state_q  <= acsu_pkg::st_idle;
         acc_q    <= acsu_pkg::ACC_RESET;
         loaded_q <= 1'b0;
         zero_q   <= 1'b0;
         dbl_q    <= 1'b0;
         lo_q     <= acsu_pkg::ADDR_RESET;
         rd_q     <= 1'b0;
         wr_q     <= 1'b0;
         addr_q   <= acsu_pkg::ADDR_RESET;
         wdata_q  <= acsu_pkg::ADDR_RESET;
      end
      else
      begin
         state_q  <= state_d;
         acc_q    <= acc_d;
         loaded_q <= loaded_d;
         zero_q   <= zero_d;
         dbl_q    <= dbl_d;
         lo_q     <= lo_d;
         rd_q     <= rd_d;
         wr_q     <= wr_d;
         addr_q   <= addr_d;
         wdata_q  <= wdata_d;
      end
   end

   acsu_stack u_stack
   (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .st      (stk)
   );

   assign mem_rd_en      = rd_q;
   assign mem_wr_en      = wr_q;
   assign mem_addr       = addr_q;
   assign mem_wr_data    = wdata_q;
   assign acc_value      = acc_q;
   assign stack_top      = stk.top;
   assign stack_depth    = stk.depth;
   assign zero_load_flag = zero_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_wr_lo;
      mem_wr_en && mem_wr_data == $past(acc_q[15:0]);
   endsequence
   sequence s_wr_hi(logic [15:0] a);
      mem_wr_en && mem_addr == a + 16'h0001 && mem_wr_data == acc_q[31:16];
   endsequence

   a_scan_clears_acc: assert property (end_of_scan |=> acc_q == 32'h0000_0000 && !loaded_q) // RULE1
      else $error("End of scan did not clear the accumulator.");
   a_first_load_direct: assert property (load_commit && !loaded_q |-> !stk.push) // RULE2
      else $error("First load of the scan pushed the stack.");
   a_next_load_push: assert property (load_commit && loaded_q && !end_of_scan |-> stk.push && stk.push_data == acc_q) // RULE2
      else $error("Back-to-back load did not push the accumulator.");
   a_out_then_overwrite: assert property (accept && is_out(op_code) |=> !loaded_q) // RULE3
      else $error("Output did not cancel the pending push.");
   a_pop_takes_top: assert property (stk.pop |=> acc_q == $past(stk.top)) // RULE6
      else $error("Pop did not move the stack top into the accumulator.");
   a_word_high_zero: assert property (load_commit && !dbl_q && !(accept && op_code == acsu_pkg::load_double_word_op) && !end_of_scan |=> acc_q[31:16] == 16'h0000) // RULE7
      else $error("Word load left the upper half non-zero.");
   a_double_word_order: assert property (state_q == acsu_pkg::st_hi_data && !end_of_scan |=> acc_q == {$past(mem_rd_data), $past(lo_q)}) // RULE8 RULE14
      else $error("Double load word order is wrong.");
   a_double_out_seq: assert property (accept && op_code == acsu_pkg::out_double_word_op |=> s_wr_lo ##1 s_wr_hi($past(mem_addr))) // RULE9
      else $error("Double output did not write two consecutive words.");
   a_zero_flag_set: assert property (load_commit && !end_of_scan |=> zero_load_flag == (acc_q == 32'h0000_0000)) // RULE10
      else $error("Zero flag does not match the loaded value.");
   a_ptr_indirect: assert property (state_q == acsu_pkg::st_ptr_data && !end_of_scan |=> mem_rd_en && mem_addr == $past(mem_rd_data) ##1 state_q == acsu_pkg::st_lo_data) // RULE11
      else $error("Pointer content was not used as the read address.");
   a_manip_result: assert property (accept && op_code == acsu_pkg::manip_op |=> acc_q == $past(op_operand)) // RULE12
      else $error("Manipulation result did not replace the accumulator.");
   a_out_word_low: assert property (accept && op_code == acsu_pkg::out_word_op |=> mem_wr_en && mem_addr == $past(op_addr) && mem_wr_data == $past(acc_q[15:0])) // RULE13
      else $error("Single output did not write the low accumulator half.");

endmodule // acsu_top

// >>> verification/acsu_mem_model.sv
// Word-wide data memory that answers the accumulator unit's strobes.
`timescale 1ns/100ps
module acsu_mem_model
(
   // Clock.
   input  wire logic        ref_clk,
   // Memory port.
   input  wire logic        mem_rd_en,
   input  wire logic        mem_wr_en,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wr_data,
   output logic      [15:0] mem_rd_data
);
   logic [15:0] mem [0:255];
   logic [1:0]  hold_q;

   initial
   begin
      mem_rd_data = 16'h0000;
      hold_q      = 2'h0;
   end

   // Data is valid from the cycle after the strobe and held two more cycles.
   // After that it toggles, so a late sample cannot pass by luck.
   always @(posedge ref_clk)
   begin
      if (mem_wr_en)
         mem[mem_addr[7:0]] <= mem_wr_data;
      if (mem_rd_en)
      begin
         mem_rd_data <= mem[mem_addr[7:0]];
         hold_q      <= 2'h2;
      end
      else if (hold_q != 2'h0)
         hold_q <= hold_q - 2'h1;
      else
         mem_rd_data <= ~mem_rd_data;
   end
endmodule // acsu_mem_model

// >>> verification/testbench.sv
// Self-checking bench for the accumulator and stack unit.
`timescale 1ns/100ps
module testbench;
   logic                  ref_clk;
   logic                  resetn;
   logic                  op_valid;
   logic                  op_ready;
   acsu_pkg::acsu_op_type op_code;
   logic                  op_use_const;
   logic                  op_indirect;
   logic [15:0]           op_addr;
   logic [31:0]           op_operand;
   logic                  end_of_scan;
   logic                  mem_rd_en;
   logic                  mem_wr_en;
   logic [15:0]           mem_addr;
   logic [15:0]           mem_wr_data;
   logic [15:0]           mem_rd_data;
   logic [31:0]           acc_value;
   logic [31:0]           stack_top;
   logic [3:0]            stack_depth;
   logic                  zero_load_flag;
   int                    miscompares;
   int                    checked;

   acsu_top DUT (.ref_clk(ref_clk), .resetn(resetn), .op_valid(op_valid),
      .op_ready(op_ready), .op_code(op_code), .op_use_const(op_use_const),
      .op_indirect(op_indirect), .op_addr(op_addr),
      .op_operand(op_operand), .end_of_scan(end_of_scan),
      .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_addr(mem_addr),
      .mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data),
      .acc_value(acc_value), .stack_top(stack_top),
      .stack_depth(stack_depth), .zero_load_flag(zero_load_flag));

   acsu_mem_model MEM (.ref_clk(ref_clk), .mem_rd_en(mem_rd_en),
      .mem_wr_en(mem_wr_en), .mem_addr(mem_addr),
      .mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data));

   initial
      ref_clk = 1'b0;
   always
      #4 ref_clk = ~ref_clk;

   task automatic results();
      if (miscompares == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
         miscompares++;
      end
   endtask

   // Bounded wait at falling edges, so ready is looked at when settled.
   task automatic wait_ready();
      int n;
      n = 0;
      while (op_ready !== 1'b1)
      begin
         @(negedge ref_clk);
         n++;
         if (n > 20)
         begin
            miscompares++;
            results();
         end
      end
   endtask

   task automatic do_op(acsu_pkg::acsu_op_type c, logic k, logic ind,
                        logic [15:0] a, logic [31:0] d);
      @(negedge ref_clk);
      wait_ready();
      op_valid     = 1'b1;
      op_code      = c;
      op_use_const = k;
      op_indirect  = ind;
      op_addr      = a;
      op_operand   = d;
      @(negedge ref_clk);
      op_valid = 1'b0;
      op_code  = acsu_pkg::nop_op;
      wait_ready();
   endtask

   task automatic t_word_loads();
      chk("acc", 32'h0000_0000, acc_value);
      do_op(acsu_pkg::load_word_op, 1'b1, 1'b0, 16'h0000, 32'hffff_1234);
      chk("acc", 32'h0000_1234, acc_value);
      chk("depth", 32'h0, {28'h0, stack_depth});
      MEM.mem[8'h10] = 16'habcd;
      do_op(acsu_pkg::load_word_op, 1'b0, 1'b0, 16'h0010, 32'h0);
      chk("acc", 32'h0000_abcd, acc_value);
      chk("top", 32'h0000_1234, stack_top);
      chk("depth", 32'h1, {28'h0, stack_depth});
      do_op(acsu_pkg::load_word_op, 1'b1, 1'b0, 16'h0000, 32'hffff_0000);
      chk("acc", 32'h0000_0000, acc_value);
      chk("flag", 32'h1, {31'h0, zero_load_flag});
      chk("depth", 32'h2, {28'h0, stack_depth});
      do_op(acsu_pkg::manip_op, 1'b0, 1'b0, 16'h0000, 32'h0102_0304);
      chk("acc", 32'h0102_0304, acc_value);
      chk("depth", 32'h2, {28'h0, stack_depth});
   endtask

   task automatic t_out_then_load();
      do_op(acsu_pkg::out_word_op, 1'b0, 1'b0, 16'h0020, 32'h0);
      repeat (2) @(negedge ref_clk);
      chk("mem20", 32'h0000_0304, {16'h0, MEM.mem[8'h20]});
      do_op(acsu_pkg::load_word_op, 1'b1, 1'b0, 16'h0000, 32'h0000_0007);
      chk("depth", 32'h2, {28'h0, stack_depth});
      chk("top", 32'h0000_abcd, stack_top);
      do_op(acsu_pkg::nop_op, 1'b0, 1'b0, 16'h0000, 32'h0);
      chk("acc", 32'h0000_0007, acc_value);
   endtask

   task automatic t_scan_and_stack();
      @(negedge ref_clk);
      end_of_scan = 1'b1;
      @(negedge ref_clk);
      end_of_scan = 1'b0;
      chk("acc", 32'h0000_0000, acc_value);
      for (int i = 1; i <= 10; i++)
         do_op(acsu_pkg::load_word_op, 1'b1, 1'b0, 16'h0000, 32'(i));
      chk("depth", 32'h8, {28'h0, stack_depth});
      chk("top", 32'h9, stack_top);
      chk("acc", 32'ha, acc_value);
      for (int i = 9; i >= 2; i--)
      begin
         do_op(acsu_pkg::pop_op, 1'b0, 1'b0, 16'h0000, 32'h0);
         chk("acc", 32'(i), acc_value);
         chk("depth", 32'(i - 2), {28'h0, stack_depth});
      end
      do_op(acsu_pkg::pop_op, 1'b0, 1'b0, 16'h0000, 32'h0);
      chk("acc", 32'h0, acc_value);
   endtask

   task automatic t_double_and_pointer();
      MEM.mem[8'h40] = 16'h5678;
      MEM.mem[8'h41] = 16'h9abc;
      MEM.mem[8'h42] = 16'h0000;
      MEM.mem[8'h43] = 16'h0000;
      MEM.mem[8'h60] = 16'h0070;
      MEM.mem[8'h70] = 16'h4242;
      do_op(acsu_pkg::load_double_word_op, 1'b0, 1'b0, 16'h0040, 32'h0);
      chk("acc", 32'h9abc_5678, acc_value);
      chk("flag", 32'h0, {31'h0, zero_load_flag});
      do_op(acsu_pkg::out_double_word_op, 1'b0, 1'b0, 16'h0050, 32'h0);
      repeat (2) @(negedge ref_clk);
      chk("mem50", 32'h0000_5678, {16'h0, MEM.mem[8'h50]});
      chk("mem51", 32'h0000_9abc, {16'h0, MEM.mem[8'h51]});
      do_op(acsu_pkg::load_double_word_op, 1'b1, 1'b0, 16'h0000,
            32'hdead_beef);
      chk("acc", 32'hdead_beef, acc_value);
      do_op(acsu_pkg::load_double_word_op, 1'b0, 1'b0, 16'h0042, 32'h0);
      chk("acc", 32'h0, acc_value);
      chk("flag", 32'h1, {31'h0, zero_load_flag});
      do_op(acsu_pkg::load_word_op, 1'b0, 1'b1, 16'h0060, 32'h0);
      chk("acc", 32'h0000_4242, acc_value);
      chk("flag", 32'h0, {31'h0, zero_load_flag});
   endtask

   initial
   begin
      miscompares  = 0;
      checked      = 0;
      resetn       = 1'b0;
      op_valid     = 1'b0;
      op_code      = acsu_pkg::nop_op;
      op_use_const = 1'b0;
      op_indirect  = 1'b0;
      op_addr      = 16'h0000;
      op_operand   = 32'h0000_0000;
      end_of_scan  = 1'b0;
      repeat (5) @(negedge ref_clk);
      resetn = 1'b1;
      t_word_loads();
      t_out_then_load();
      t_scan_and_stack();
      t_double_and_pointer();
      results();
   end
endmodule // testbench
